// ### rtl/stp_deserializer.sv
`timescale 1ns/1ps

module stp_deserializer (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bit_clock,
  input  wire logic        serial_in_a,
  input  wire logic        serial_in_b,
  input  wire logic        slip_request,
  input  wire logic        master_reset,
  input  wire logic        clock_gate,
  output logic      [7:0]  parallel_out_bit,
  output logic             frame_clock
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_s3;
  logic [5:0] pin_f;
  logic [5:0] pin_fq;
  logic [5:0] next_pin_f;
  logic [5:0] pin_agree;

  assign pin_raw = {clock_gate, master_reset, slip_request,
                    serial_in_b, serial_in_a, bit_clock};

  // A level is accepted only once the second and third stages agree.
  assign pin_agree  = ~(pin_s2 ^ pin_s3);
  assign next_pin_f = (pin_agree & pin_s3) | (~pin_agree & pin_f);

  always_ff @(posedge clock) begin
    if (reset) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_f  <= '0;
      pin_fq <= '0;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f  <= next_pin_f;
      pin_fq <= pin_f;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register and decoded controls
  // ---------------------------------------------------------------------------
  logic [1:0] ctrl;
  wire        edge_mode_select    = ctrl[stp_pkg::CTRL_EDGE_BIT];
  wire        serial_input_select = ctrl[stp_pkg::CTRL_SEL_BIT];
  wire        dual       = ~edge_mode_select;
  wire        b_rise     = pin_f[stp_pkg::PIN_BCLK] &
                           ~pin_fq[stp_pkg::PIN_BCLK];
  wire        b_fall     = ~pin_f[stp_pkg::PIN_BCLK] &
                           pin_fq[stp_pkg::PIN_BCLK];
  wire        mres       = pin_f[stp_pkg::PIN_MRESET];
  wire        gate       = pin_f[stp_pkg::PIN_GATE];
  wire        slip       = pin_f[stp_pkg::PIN_SLIP];
  wire        clear_all  = reset | mres;
  wire        data_bit   = serial_input_select ?
                           pin_f[stp_pkg::PIN_SIN_B] :
                           pin_f[stp_pkg::PIN_SIN_A];

  // ---------------------------------------------------------------------------
  // Internal clock enable
  // ---------------------------------------------------------------------------
  logic running;
  logic armed;
  logic lead_in;

  // The gate only changes the enable on a falling bit clock edge, so an active
  // edge is never cut short by the gate.
  always_ff @(posedge clock) begin
    if (clear_all) begin
      running <= 1'b0;
    end else if (b_fall) begin
      running <= ~gate;
    end
  end

  // After a master reset the first rise while running is spent, the second captures.
  always_ff @(posedge clock) begin
    if (clear_all) begin
      armed <= 1'b1;
    end else if (running & b_rise) begin
      armed <= 1'b0;
    end
  end

  // Until the capturing rise has come, a dual-edge fall takes no bit.
  always_ff @(posedge clock) begin
    if (clear_all) begin
      lead_in <= 1'b1;
    end else if (running & b_rise & ~armed) begin
      lead_in <= 1'b0;
    end
  end

  wire fall_ok = dual & b_fall & ~lead_in;
  wire active  = running & ~armed & (b_rise | fall_ok);

  // ---------------------------------------------------------------------------
  // Slip request qualification
  // ---------------------------------------------------------------------------
  logic [2:0] slip_cnt;
  logic       slip_used;
  logic       pending;

  wire [2:0] slip_need = dual ? stp_pkg::SLIP_HOLD_DUAL :
                                stp_pkg::SLIP_HOLD_RISE;
  wire       slip_hit  = slip & b_rise & ~slip_used &
                         (slip_cnt == slip_need - 3'h1);
  wire       swallow   = active & pending;
  wire       take      = active & ~pending;

  always_ff @(posedge clock) begin
    if (clear_all | ~slip) begin
      slip_cnt <= 3'h0;
    end else if (b_rise & (slip_cnt != stp_pkg::SLIP_CNT_MAX)) begin
      slip_cnt <= slip_cnt + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (clear_all | ~slip) begin
      slip_used <= 1'b0;
    end else if (slip_hit) begin
      slip_used <= 1'b1;
    end
  end

  // A new qualification wins over the clear by a swallow.
  always_ff @(posedge clock) begin
    if (clear_all) begin
      pending <= 1'b0;
    end else if (slip_hit) begin
      pending <= 1'b1;
    end else if (swallow) begin
      pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Shift, word hold and output stage
  // ---------------------------------------------------------------------------
  logic [2:0] cnt;
  logic [7:0] shift;
  logic [7:0] hold_a;
  logic [7:0] hold_b;

  wire [2:0] next_cnt   = cnt + 3'h1;
  wire [7:0] next_shift = {data_bit, shift[7:1]};
  wire       word_done  = take & (cnt == stp_pkg::WORD_LAST);
  wire       out_load   = take & (cnt == stp_pkg::OUT_PHASE);

  always_ff @(posedge clock) begin
    if (clear_all) begin
      cnt   <= 3'h0;
      shift <= 8'h00;
    end else if (take) begin
      cnt   <= next_cnt;
      shift <= next_shift;
    end
  end

  always_ff @(posedge clock) begin
    if (clear_all) begin
      hold_a <= 8'h00;
      hold_b <= 8'h00;
    end else if (word_done) begin
      hold_a <= next_shift;
      hold_b <= hold_a;
    end
  end

  // Words leave twelve accepted bits after their last bit.
  always_ff @(posedge clock) begin
    if (clear_all) begin
      parallel_out_bit <= 8'h00;
    end else if (out_load) begin
      parallel_out_bit <= hold_b;
    end
  end

  // One framing period spans eight accepted bits.
  always_ff @(posedge clock) begin
    if (clear_all) begin
      frame_clock <= 1'b0;
    end else if (take) begin
      frame_clock <= ~cnt[stp_pkg::FRAME_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------------------
  wire        access   = psel & penable;
  wire        done     = access & pready;
  wire        hit_ctrl = (paddr == stp_pkg::ADDR_CTRL);
  wire        hit_stat = (paddr == stp_pkg::ADDR_STATUS);
  wire        hit_word = (paddr == stp_pkg::ADDR_WORD);
  wire        unmapped = ~(hit_ctrl | hit_stat | hit_word);
  wire [31:0] stat_val = {21'h0, cnt, 5'h0, pending, armed, running};
  wire [31:0] rd_mux;

  assign rd_mux = hit_ctrl ? {30'h0, ctrl} :
                  hit_stat ? stat_val :
                  hit_word ? {24'h0, parallel_out_bit} : 32'h0;

  // Cleared control bits select dual edge and input A.
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl <= stp_pkg::CTRL_RESET[1:0];
    end else if (done & pwrite & hit_ctrl) begin
      ctrl <= pwdata[1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & unmapped;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_reset_stop: assert property (
    @(posedge clock) disable iff (reset)
    mres |=> !running && armed)
    else $error("internal clock ran during master reset");

  a_gate_off: assert property (
    @(posedge clock) disable iff (reset)
    b_fall && gate && !mres |=> !running)
    else $error("gate did not suspend at falling edge");

  a_gate_on: assert property (
    @(posedge clock) disable iff (reset)
    b_fall && !gate && !mres |=> running)
    else $error("gate did not resume at falling edge");

  a_rise_only: assert property (
    @(posedge clock) disable iff (reset)
    edge_mode_select && b_fall && !mres |=> $stable(cnt) && $stable(shift))
    else $error("falling edge taken in rising-only mode");

  a_first_rise: assert property (
    @(posedge clock) disable iff (reset)
    armed && running && b_rise && !mres |=> !armed && cnt == 3'h0)
    else $error("first rise after reset was not skipped");

  a_slip_skip: assert property (
    @(posedge clock) disable iff (reset)
    swallow && !mres |=> $stable(cnt) && $stable(frame_clock) && !pending)
    else $error("slip did not swallow exactly one bit");

  a_slip_once: assert property (
    @(posedge clock) disable iff (reset)
    pending |-> slip_used || !slip)
    else $error("slip pending without a qualifying pulse");

  a_word_order: assert property (
    @(posedge clock) disable iff (reset)
    word_done && !mres |=> hold_a == {$past(data_bit), $past(shift[7:1])})
    else $error("word bits landed in the wrong order");

  a_out_phase: assert property (
    @(posedge clock) disable iff (reset)
    !$past(mres) && $changed(parallel_out_bit) |->
      $past(take) && $past(cnt) == stp_pkg::OUT_PHASE)
    else $error("parallel word updated off its phase");

  a_frame_edge: assert property (
    @(posedge clock) disable iff (reset)
    $rose(frame_clock) |-> $past(cnt) == 3'h0 && cnt == 3'h1)
    else $error("framing clock rose away from word start");

endmodule

// ### rtl/stp_pkg.sv
package stp_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned WORD_W   = 8;
  localparam int unsigned CNT_W    = 3;
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PIN_W    = 6;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_WORD   = 12'h008;

  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam int unsigned CTRL_EDGE_BIT   = 0;
  localparam int unsigned CTRL_SEL_BIT    = 1;
  localparam int unsigned CTRL_USED_W     = 2;

  localparam int unsigned STAT_RUN_BIT    = 0;
  localparam int unsigned STAT_ARM_BIT    = 1;
  localparam int unsigned STAT_PEND_BIT   = 2;
  localparam int unsigned STAT_CNT_LSB    = 8;

  // ---------------------------------------------------------------------------
  // Pin vector layout
  // ---------------------------------------------------------------------------
  localparam int unsigned PIN_BCLK   = 0;
  localparam int unsigned PIN_SIN_A  = 1;
  localparam int unsigned PIN_SIN_B  = 2;
  localparam int unsigned PIN_SLIP   = 3;
  localparam int unsigned PIN_MRESET = 4;
  localparam int unsigned PIN_GATE   = 5;

  // ---------------------------------------------------------------------------
  // Timing in bit clock terms
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  SLIP_HOLD_DUAL = 3'h2;
  localparam logic [2:0]  SLIP_HOLD_RISE = 3'h3;
  localparam logic [2:0]  SLIP_CNT_MAX   = 3'h3;
  localparam int unsigned LAT_DUAL_CYC   = 6;
  localparam int unsigned LAT_RISE_CYC   = 12;
  // Both modes come to twelve active edges between a bit and its output.
  localparam int unsigned LAT_EDGES      = 2 * LAT_DUAL_CYC;
  localparam logic [2:0]  WORD_LAST      = 3'(WORD_W - 1);
  localparam logic [2:0]  OUT_PHASE      =
    3'((WORD_W - 1 + LAT_EDGES) % WORD_W);
  localparam int unsigned FRAME_BIT      = CNT_W - 1;

endpackage

// ### testbench/stp_serial_source.sv
`timescale 1ns/1ps
// ------------------------------------------
// Serial source: the bit clock stands still between calls.
// ------------------------------------------
module stp_serial_source (
  input  wire logic clock,
  output logic      bit_clock,
  output logic      serial_in_a,
  output logic      serial_in_b
);
  initial begin
    bit_clock   = 1'b0;
    serial_in_a = 1'b0;
    serial_in_b = 1'b0;
  end

  // Lanes change mid-phase so they stay still around each filtered edge.
  task automatic half(input logic a, input logic b);
    repeat (4) @(posedge clock);
    serial_in_a <= a;
    serial_in_b <= b;
    repeat (8) @(posedge clock);
    bit_clock <= ~bit_clock;
    repeat (8) @(posedge clock);
  endtask
endmodule

// ### testbench/test_serial_to_parallel_1to8_bitslip.sv
`timescale 1ns/1ps
module test_serial_to_parallel_1to8_bitslip;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        bit_clock;
  logic        sin_a;
  logic        sin_b;
  logic        slip_request = 1'b0;
  logic        master_reset = 1'b0;
  logic        clock_gate = 1'b0;
  logic [7:0]  parallel_out_bit;
  logic        frame_clock;
  int          err_total = 0;
  int          checked = 0;
  int          run, skip, cnt, done, pend, slipped, act, nbit, acc, ew, ok;
  int          armed = 1;
  int          words[$];
  int          lasts[$];
  bit          dual;
  bit          sel;

  always #2.5 clock = ~clock;

  stp_serial_source src (.clock(clock), .bit_clock(bit_clock),
    .serial_in_a(sin_a), .serial_in_b(sin_b));

  stp_deserializer dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock(bit_clock), .serial_in_a(sin_a), .serial_in_b(sin_b),
    .slip_request(slip_request), .master_reset(master_reset),
    .clock_gate(clock_gate), .parallel_out_bit(parallel_out_bit),
    .frame_clock(frame_clock));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge clock);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 20) check("pready", 32'h0, 32'h1);
  endtask

  // ------------------------------------------
  // Reference model, one call per bit clock edge.
  // ------------------------------------------
  task automatic clear_model();
    {run, skip, cnt, done, pend, slipped, act, nbit, acc} = '0;
    armed = 1;
    words.delete();
    lasts.delete();
  endtask

  task automatic model_edge(input bit rise, input bit d);
    bit a;
    a = 0;
    if (master_reset) return;
    if (!rise) begin
      // A dual-edge fall still takes a bit on the edge that suspends.
      a = run && skip == 0 && dual;
      if (!run && !clock_gate) begin
        run = 1;
        skip = armed ? 2 : 1;
        armed = 0;
      end else if (run && clock_gate) begin
        run = 0;
      end
    end else if (run && skip == 2) skip = 1;
    else if (run) begin
      skip = 0;
      a = 1;
    end
    if (a && pend) begin
      pend = 0;
      slipped = 1;
    end else if (a) begin
      acc |= int'(d) << (nbit % 8);
      nbit++;
      act++;
      if (nbit % 8 == 0) begin
        words.push_back(acc);
        lasts.push_back(act);
        acc = 0;
      end
    end
    if (!slip_request) {cnt, done} = '0;
    else if (rise && run && done == 0) cnt++;
    if (done == 0 && cnt == (dual ? 2 : 3)) begin
      pend = 1;
      done = 1;
    end
  endtask

  task automatic check_edge();
    int w, dd, fe;
    w = -1;
    foreach (lasts[i]) if (lasts[i] + 12 <= act) w = i;
    dd = (w < 0) ? 0 : act - lasts[w] - 12;
    ew = (w < 0) ? 0 : words[w];
    ok = !slipped || (dd >= 2 && dd <= 5);
    if (ok)
      check("word", {24'h0, parallel_out_bit}, 32'(ew));
    fe = nbit > 0 && (nbit - 1) % 8 < 4;
    check("frame", {31'h0, frame_clock}, 32'(fe));
  endtask

  // ------------------------------------------
  // Main sequence.
  // ------------------------------------------
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    stop_test();
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    logic [31:0] r;
    r = 32'h12257ea1;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, 12'h000, 32'h0, rd, er);
    check("ctrl reset", rd, 32'h0);
    apb(1'b1, 12'h004, 32'hff, rd, er);
    apb(1'b0, 12'h004, 32'h0, rd, er);
    check("status", rd, 32'h2);
    apb(1'b0, 12'h00c, 32'h0, rd, er);
    check("unmapped", {31'h0, er}, 32'h1);
    for (int cfg = 0; cfg < 4; cfg++) begin
      apb(1'b1, 12'h000, 32'(cfg), rd, er);
      apb(1'b0, 12'h000, 32'h0, rd, er);
      check("ctrl", rd, 32'(cfg));
      dual = !cfg[0];
      sel = cfg[1];
      @(posedge clock);
      master_reset <= 1'b1;
      clear_model();
      repeat (2) src.half(r[2], r[3]);
      check("rst word", 32'(parallel_out_bit), 32'h0);
      check("reset frame", {31'h0, frame_clock}, 32'h0);
      @(posedge clock);
      master_reset <= 1'b0;
      for (int h = 0; h < 80; h++) begin
        @(posedge clock);
        clock_gate <= (h >= 16 && h < 22);
        slip_request <= (h >= 30 && h < 38);
        r = lfsr(r);
        src.half(r[0], r[1]);
        model_edge(bit_clock, sel ? r[1] : r[0]);
        check_edge();
      end
      apb(1'b0, 12'h008, 32'h0, rd, er);
      if (ok)
        check("word reg", rd, 32'(ew));
      $display("test %0d done", cfg);
    end
    stop_test();
  end
endmodule
